// *** sound_pkg.sv ***
// Shared constants and types for the addressable latch and tone/noise generator.
package sound_pkg;
	// System clock and tone prescaler: 4 MHz reference divided by 16 per tone tick.
	localparam int unsigned CLOCK_HZ = 50_000_000;
	localparam int unsigned REF_HZ = 4_000_000;
	localparam int unsigned PRESCALE_DIV = 16;
	localparam int unsigned TICK_CYCLES = CLOCK_HZ / (REF_HZ / PRESCALE_DIV);
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

	// Latch output bit positions.
	localparam int unsigned SOUND_WE_BIT = 0;
	localparam int unsigned SPEECH_RD_BIT = 1;
	localparam int unsigned SPEECH_WR_BIT = 2;
	localparam int unsigned KEYBOARD_WE_BIT = 3;
	localparam int unsigned SCROLL_LO_BIT = 4;
	localparam int unsigned SCROLL_HI_BIT = 5;
	localparam int unsigned CAPS_BIT = 6;
	localparam int unsigned SHIFT_BIT = 7;

	// Scroll codes {high, low} and the screen offset in kilobytes.
	localparam logic [1:0] SCROLL_CODE_12K = 2'h3;
	localparam logic [1:0] SCROLL_CODE_16K = 2'h0;
	localparam logic [1:0] SCROLL_CODE_22K = 2'h2;
	localparam logic [4:0] SCROLL_KB_12 = 5'h0c;
	localparam logic [4:0] SCROLL_KB_16 = 5'h10;
	localparam logic [4:0] SCROLL_KB_22 = 5'h16;
	localparam logic [4:0] SCROLL_KB_24 = 5'h18;

	// Command byte fields.
	localparam int unsigned CMD_FIRST_BIT = 7;
	localparam int unsigned FEEDBACK_BIT = 2;

	// Register select codes.
	localparam logic [2:0] REG_TONE3_FREQ = 3'h0;
	localparam logic [2:0] REG_TONE3_VOL = 3'h1;
	localparam logic [2:0] REG_TONE1_FREQ = 3'h4;
	localparam logic [2:0] REG_NOISE_CTRL = 3'h6;
	localparam logic [2:0] REG_NOISE_VOL = 3'h7;

	// Noise rate dividers in tone ticks; rate code 3 follows tone 1.
	localparam logic [1:0] NOISE_RATE_TONE1 = 2'h3;
	localparam logic [9:0] NOISE_DIV_LOW = 10'h040;
	localparam logic [9:0] NOISE_DIV_MED = 10'h020;
	localparam logic [9:0] NOISE_DIV_HIGH = 10'h010;
	localparam logic [14:0] LFSR_SEED = 15'h4000;
	localparam logic [3:0] ATTEN_OFF = 4'hf;

	// APB register byte offsets and reset value.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LATCH = 8'h04;
	localparam logic [7:0] ADDR_TONE1 = 8'h08;
	localparam logic [7:0] ADDR_TONE2 = 8'h0c;
	localparam logic [7:0] ADDR_TONE3 = 8'h10;
	localparam logic [7:0] ADDR_NOISE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	typedef struct packed {
		logic [9:0] divisor;
		logic [3:0] atten;
	} tone_cfg_t;

	typedef struct packed {
		logic feedback;
		logic [1:0] rate;
		logic [3:0] atten;
	} noise_cfg_t;
endpackage

// *** addr_latch.sv ***
// Eight-bit addressable output latch loaded one bit at a time.
`timescale 1ns/10ps
`default_nettype none
module addr_latch #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic clock_i, // System clock.
	input wire logic reset_n_i, // Synchronous reset, active low.
	input wire logic [$clog2(WIDTH)-1:0] sel_i, // Bit being addressed.
	input wire logic data_i, // Value for the addressed bit.
	output logic [WIDTH-1:0] bits_o // Latched outputs.
);
	initial begin
		if (WIDTH < 2 || WIDTH > 32) begin
			$error("addr_latch: WIDTH out of range");
		end
	end

	// The addressed bit follows the data line; all others keep their value.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			bits_o <= '0;
		end else begin
			bits_o[sel_i] <= data_i;
		end
	end

	a_latch_load: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		1'b1 |=> bits_o[$past(sel_i)] == $past(data_i)) else $error("latch bit not loaded");
	a_latch_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		1'b1 |=> ((bits_o ^ $past(bits_o)) & ~(WIDTH'(1) << $past(sel_i))) == '0)
		else $error("unaddressed latch bit changed");
endmodule
`default_nettype wire

// *** tone_channel.sv ***
// Square-wave divider: toggles each time a reloading down-counter expires.
`timescale 1ns/10ps
`default_nettype none
module tone_channel #(
	parameter int unsigned WIDTH = 10
) (
	input wire logic clock_i, // System clock.
	input wire logic reset_n_i, // Synchronous reset, active low.
	input wire logic tick_i, // Prescaled count pulse.
	input wire logic [WIDTH-1:0] divisor_i, // Reload value.
	output logic square_o // Square-wave output.
);
	logic [WIDTH-1:0] count;

	initial begin
		if (WIDTH < 2) begin
			$error("tone_channel: WIDTH too small");
		end
	end

	// A divisor of zero or one toggles on every tick.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			count <= '0;
			square_o <= 1'b0;
		end else if (tick_i) begin
			if (count <= WIDTH'(1)) begin
				count <= divisor_i;
				square_o <= ~square_o;
			end else begin
				count <= count - WIDTH'(1);
			end
		end
	end

	a_tone_toggle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		tick_i && count <= WIDTH'(1) |=> square_o != $past(square_o)) else $error("no toggle");
	a_tone_steady: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!(tick_i && count <= WIDTH'(1)) |=> $stable(square_o)) else $error("stray toggle");
endmodule
`default_nettype wire

// *** sound_top.sv ***
// Addressable latch, command decoder, tone and noise generator and mixer behind APB.
`timescale 1ns/10ps
`default_nettype none
module sound_top (
	input wire logic clock_i, // System clock, 50 MHz.
	input wire logic reset_n_i, // Synchronous reset, active low.
	input wire logic psel_i, // APB select.
	input wire logic penable_i, // APB enable.
	input wire logic pwrite_i, // APB direction, high for write.
	input wire logic [7:0] paddr_i, // APB byte address.
	input wire logic [31:0] pwdata_i, // APB write data.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready.
	output logic pslverr_o, // APB error for unmapped address.
	input wire logic [2:0] latch_bit_select_lines_i, // Latch bit select pins.
	input wire logic latch_data_line_i, // Latch data pin.
	input wire logic [7:0] slow_data_bus_i, // Command byte pins.
	output logic speech_read_select_bit_o, // Speech read select.
	output logic speech_write_select_bit_o, // Speech write select.
	output logic keyboard_write_enable_bit_o, // Keyboard write enable.
	output logic caps_indicator_bit_o, // Caps indicator drive.
	output logic shift_indicator_bit_o, // Shift indicator drive.
	output logic [4:0] scroll_offset_kbytes_o, // Screen start offset in KB.
	output logic [2:0] tone_o, // Tone squares, index 0 is tone 1.
	output logic noise_o, // Noise output.
	output logic [5:0] mix_o // Mixed level of all channels.
);
	logic [3:0] latch_pins_meta;
	logic [3:0] latch_pins;
	logic [7:0] bus_meta;
	logic [7:0] bus_sync;
	logic [7:0] latch_bits;
	logic we_prev;
	logic write_strobe;
	logic [7:0] cmd;
	logic [2:0] last_sel;
	sound_pkg::tone_cfg_t tone_cfg [3];
	sound_pkg::noise_cfg_t noise_cfg;
	logic noise_restart;
	logic enable;
	logic [7:0] tick_count;
	logic tick;
	logic [2:0] tone_sq;
	logic [9:0] noise_div;
	logic noise_div_sq;
	logic noise_clk;
	logic noise_clk_prev;
	logic noise_shift;
	logic [14:0] lfsr;
	logic next_lfsr_in;
	logic [5:0] next_mix;
	logic [31:0] next_rdata;
	logic addr_ok;

	// Latch and command bus pins pass two flip-flops before any logic reads them.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			latch_pins_meta <= '0;
			latch_pins <= '0;
			bus_meta <= '0;
			bus_sync <= '0;
		end else begin
			latch_pins_meta <= {latch_data_line_i, latch_bit_select_lines_i};
			latch_pins <= latch_pins_meta;
			bus_meta <= slow_data_bus_i;
			bus_sync <= bus_meta;
		end
	end

	addr_latch #(
		.WIDTH(8)
	) u_latch (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.sel_i(latch_pins[2:0]),
		.data_i(latch_pins[3]),
		.bits_o(latch_bits)
	);

	// Latch bits steer the speech, keyboard and indicator lines.
	assign speech_read_select_bit_o = latch_bits[sound_pkg::SPEECH_RD_BIT];
	assign speech_write_select_bit_o = latch_bits[sound_pkg::SPEECH_WR_BIT];
	assign keyboard_write_enable_bit_o = latch_bits[sound_pkg::KEYBOARD_WE_BIT];
	assign caps_indicator_bit_o = latch_bits[sound_pkg::CAPS_BIT];
	assign shift_indicator_bit_o = latch_bits[sound_pkg::SHIFT_BIT];

	// Scroll code to screen start offset.
	always_comb begin
		case ({latch_bits[sound_pkg::SCROLL_HI_BIT], latch_bits[sound_pkg::SCROLL_LO_BIT]})
			sound_pkg::SCROLL_CODE_12K: scroll_offset_kbytes_o = sound_pkg::SCROLL_KB_12;
			sound_pkg::SCROLL_CODE_16K: scroll_offset_kbytes_o = sound_pkg::SCROLL_KB_16;
			sound_pkg::SCROLL_CODE_22K: scroll_offset_kbytes_o = sound_pkg::SCROLL_KB_22;
			default: scroll_offset_kbytes_o = sound_pkg::SCROLL_KB_24;
		endcase
	end

	// The write enable is active low; the byte is taken when it returns high,
	// by which time the host has held the bus stable through the low pulse.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			we_prev <= 1'b0;
		end else begin
			we_prev <= latch_bits[sound_pkg::SOUND_WE_BIT];
		end
	end
	assign write_strobe = latch_bits[sound_pkg::SOUND_WE_BIT] & ~we_prev;
	assign cmd = bus_sync;

	// Maps a frequency or volume select code to a tone index (0 is tone 1).
	function automatic logic [1:0] tone_index(input logic [2:0] sel);
		return 2'h2 - sel[2:1];
	endfunction

	// Command decoder: first bytes select and load low data, second bytes load
	// the high divisor bits of the remembered register.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			last_sel <= sound_pkg::REG_TONE3_FREQ;
			for (int i = 0; i < 3; i++) begin
				tone_cfg[i].divisor <= '0;
				tone_cfg[i].atten <= sound_pkg::ATTEN_OFF;
			end
			noise_cfg.feedback <= 1'b0;
			noise_cfg.rate <= '0;
			noise_cfg.atten <= sound_pkg::ATTEN_OFF;
			noise_restart <= 1'b0;
		end else begin
			noise_restart <= 1'b0;
			if (write_strobe && cmd[sound_pkg::CMD_FIRST_BIT]) begin
				last_sel <= cmd[6:4];
				case (cmd[6:4])
					sound_pkg::REG_NOISE_CTRL: begin
						noise_cfg.feedback <= cmd[sound_pkg::FEEDBACK_BIT];
						noise_cfg.rate <= cmd[1:0];
						noise_restart <= 1'b1;
					end
					sound_pkg::REG_NOISE_VOL: begin
						noise_cfg.atten <= cmd[3:0];
					end
					default: begin
						if (cmd[4]) begin
							tone_cfg[tone_index(cmd[6:4])].atten <= cmd[3:0];
						end else begin
							tone_cfg[tone_index(cmd[6:4])].divisor[3:0] <= cmd[3:0];
						end
					end
				endcase
			end else if (write_strobe) begin
				// Bit 6 is ignored; only a remembered tone frequency select takes it.
				if (!last_sel[0] && last_sel != sound_pkg::REG_NOISE_CTRL) begin
					tone_cfg[tone_index(last_sel)].divisor[9:4] <= cmd[5:0];
				end
			end
		end
	end

	a_first_byte: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && cmd[7] |=> last_sel == $past(cmd[6:4])) else $error("select lost");
	a_second_byte: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && !cmd[7] && last_sel == sound_pkg::REG_TONE1_FREQ
		|=> tone_cfg[0].divisor[9:4] == $past(cmd[5:0]) && last_sel == $past(last_sel))
		else $error("second frequency byte not applied");
	a_volume_byte: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && cmd[7:4] == {1'b1, sound_pkg::REG_TONE3_VOL}
		|=> tone_cfg[2].atten == $past(cmd[3:0])) else $error("tone 3 volume not applied");
	a_noise_byte: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && cmd[7:4] == {1'b1, sound_pkg::REG_NOISE_CTRL}
		|=> noise_cfg.feedback == $past(cmd[2]) && noise_cfg.rate == $past(cmd[1:0]))
		else $error("noise control not applied");
	a_second_ignored: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && !cmd[7] && last_sel[0]
		|=> tone_cfg[0] == $past(tone_cfg[0]) && tone_cfg[1] == $past(tone_cfg[1])
		&& tone_cfg[2] == $past(tone_cfg[2])) else $error("second byte not ignored");
	a_repeat_second: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		write_strobe && !cmd[7] && last_sel == sound_pkg::REG_TONE3_FREQ
		|=> tone_cfg[2].divisor[9:4] == $past(cmd[5:0])) else $error("tone 3 high bits lost");

	// Control register: bit 0 runs the prescaler and unmutes the mix.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			enable <= sound_pkg::CTRL_ENABLE_RESET;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == sound_pkg::ADDR_CTRL) begin
			enable <= pwdata_i[0];
		end
	end

	// Prescaler: one tone tick every 16 cycles of the 4 MHz reference.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			tick_count <= '0;
		end else if (enable) begin
			tick_count <= (tick_count == sound_pkg::TICK_LAST) ? 8'h00 : tick_count + 8'h01;
		end
	end
	assign tick = enable && tick_count == sound_pkg::TICK_LAST;

	a_tick_gap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		tick |=> !tick [*8]) else $error("prescaler ticks too close");

	// Three tone channels, each toggling every N ticks: period 32N reference cycles.
	for (genvar g = 0; g < 3; g++) begin : g_tone
		tone_channel #(
			.WIDTH(10)
		) u_tone (
			.clock_i(clock_i),
			.reset_n_i(reset_n_i),
			.tick_i(tick),
			.divisor_i(tone_cfg[g].divisor),
			.square_o(tone_sq[g])
		);
	end
	assign tone_o = tone_sq;

	// Noise rate divider; code 3 takes tone 1 instead.
	always_comb begin
		case (noise_cfg.rate)
			2'h0: noise_div = sound_pkg::NOISE_DIV_LOW;
			2'h1: noise_div = sound_pkg::NOISE_DIV_MED;
			default: noise_div = sound_pkg::NOISE_DIV_HIGH;
		endcase
	end

	tone_channel #(
		.WIDTH(10)
	) u_noise_div (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.tick_i(tick),
		.divisor_i(noise_div),
		.square_o(noise_div_sq)
	);

	assign noise_clk = (noise_cfg.rate == sound_pkg::NOISE_RATE_TONE1) ? tone_sq[0] : noise_div_sq;
	assign noise_shift = noise_clk & ~noise_clk_prev;

	// Noise shift register; a noise control write restarts it from the seed.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			noise_clk_prev <= 1'b0;
		end else begin
			noise_clk_prev <= noise_clk;
		end
	end

	assign next_lfsr_in = noise_cfg.feedback ? (lfsr[0] ^ lfsr[1]) : lfsr[0];

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			lfsr <= sound_pkg::LFSR_SEED;
		end else if (noise_restart) begin
			lfsr <= sound_pkg::LFSR_SEED;
		end else if (noise_shift) begin
			lfsr <= {next_lfsr_in, lfsr[14:1]};
		end
	end
	assign noise_o = lfsr[0];

	a_noise_periodic: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		noise_shift && !noise_restart && !noise_cfg.feedback |=> lfsr[14] == $past(lfsr[0]))
		else $error("periodic feedback wrong");
	a_noise_white: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		noise_shift && !noise_restart && noise_cfg.feedback
		|=> lfsr[14] == ($past(lfsr[0]) ^ $past(lfsr[1]))) else $error("white feedback wrong");
	a_noise_tone1: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		noise_cfg.rate == 2'h3 && $past(noise_cfg.rate) == 2'h3
		&& tone_sq[0] && !$past(tone_sq[0]) |-> noise_shift)
		else $error("noise not following tone 1");

	// Mixer: each channel adds its level while its output is high.
	always_comb begin
		next_mix = '0;
		for (int i = 0; i < 3; i++) begin
			if (tone_sq[i]) begin
				next_mix = next_mix + {2'h0, sound_pkg::ATTEN_OFF - tone_cfg[i].atten};
			end
		end
		if (lfsr[0]) begin
			next_mix = next_mix + {2'h0, sound_pkg::ATTEN_OFF - noise_cfg.atten};
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			mix_o <= '0;
		end else begin
			mix_o <= enable ? next_mix : 6'h00;
		end
	end

	a_silent_mix: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		tone_cfg[0].atten == 4'hf && tone_cfg[1].atten == 4'hf && tone_cfg[2].atten == 4'hf
		&& noise_cfg.atten == 4'hf |=> mix_o == 6'h00) else $error("silenced channels audible");
	a_loud_tone: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		enable && tone_sq == 3'b001 && !lfsr[0] && tone_cfg[0].atten == 4'h0
		|=> mix_o == 6'h0f) else $error("tone 1 at full volume not 15");

	// APB read mux, captured in the setup phase so data leave a flip-flop.
	always_comb begin
		addr_ok = 1'b1;
		next_rdata = '0;
		case (paddr_i)
			sound_pkg::ADDR_CTRL: next_rdata = {31'h0, enable};
			sound_pkg::ADDR_LATCH: next_rdata = {24'h0, latch_bits};
			sound_pkg::ADDR_TONE1: next_rdata = {18'h0, tone_cfg[0]};
			sound_pkg::ADDR_TONE2: next_rdata = {18'h0, tone_cfg[1]};
			sound_pkg::ADDR_TONE3: next_rdata = {18'h0, tone_cfg[2]};
			sound_pkg::ADDR_NOISE: next_rdata = {25'h0, noise_cfg};
			sound_pkg::ADDR_STATUS: next_rdata = {7'h00, lfsr, mix_o, noise_o, tone_sq};
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i) begin
			prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
		end
	end

	// Zero-wait slave; an unmapped address errors in the access phase.
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_ok;

	a_scroll_map: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		latch_bits[5:4] == 2'b10 |-> scroll_offset_kbytes_o == 5'h16) else $error("scroll map");
endmodule
`default_nettype wire

// *** host_port_model.sv ***
// Host model that drives the latch pins and the slow command bus.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
	input wire logic clock_i, // System clock.
	output logic [2:0] bit_sel_o, // Latch bit select lines.
	output logic bit_data_o, // Latch data line.
	output logic [7:0] bus_o // Slow command bus.
);
	localparam int WE_LOW_CYCLES = 400;

	// Idle pins: write enable bit addressed low, as the latch clears it at reset,
	// so no stray byte is taken before the first send; bus drives a pattern.
	initial begin
		bit_sel_o = 3'h0;
		bit_data_o = 1'b0;
		bus_o = 8'h5a;
	end

	// Select and data move together and stay for four cycles, one bit per write.
	task automatic set_latch(input logic [2:0] sel, input logic val);
		@(posedge clock_i);
		bit_sel_o <= sel;
		bit_data_o <= val;
		repeat (4) @(posedge clock_i);
	endtask

	// Byte goes on the bus first, then write enable is held low for 8 us.
	task automatic send_byte(input logic [7:0] b);
		@(posedge clock_i);
		bus_o <= b;
		repeat (3) @(posedge clock_i);
		set_latch(3'h0, 1'b0);
		repeat (WE_LOW_CYCLES) @(posedge clock_i);
		set_latch(3'h0, 1'b1);
		repeat (6) @(posedge clock_i);
		// Released bus shows the inverse so a stale byte cannot pass.
		bus_o <= ~b;
	endtask
endmodule
`default_nettype wire

// *** tone_noise_sound_generator_bench.sv ***
// Self-checking bench for the latch and the tone and noise generator.
`timescale 1ns/10ps
`default_nettype none
module tone_noise_sound_generator_bench;
	logic clock_i = 1'b0;
	logic reset_n_i;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] sel;
	logic dat;
	logic [7:0] bus;
	logic spr, spw, kbw, caps, shift, noise;
	logic [4:0] scroll;
	logic [2:0] tone;
	logic [5:0] mix;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	// Clock at 50 MHz.
	always #10 clock_i = ~clock_i;

	sound_top sound_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.latch_bit_select_lines_i(sel), .latch_data_line_i(dat), .slow_data_bus_i(bus),
		.speech_read_select_bit_o(spr), .speech_write_select_bit_o(spw),
		.keyboard_write_enable_bit_o(kbw), .caps_indicator_bit_o(caps),
		.shift_indicator_bit_o(shift), .scroll_offset_kbytes_o(scroll), .tone_o(tone),
		.noise_o(noise), .mix_o(mix));

	host_port_model host_port_model_i (.clock_i(clock_i), .bit_sel_o(sel),
		.bit_data_o(dat), .bus_o(bus));

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors = num_errors + 1;
			$display("MISMATCH at %0t: timeout", $time);
			give_verdict();
		end
	end

	// Compares a value with case equality.
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; the answer is taken at the edge where pready is high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		@(posedge clock_i);
		while (pready !== 1'b1) begin
			@(posedge clock_i);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check_val(rd, exp, msg);
	endtask

	// Latch bits, indicator outputs, scroll codes and holding.
	task automatic test_latch();
		logic [1:0] codes [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
		logic [4:0] kb [4] = '{5'h0c, 5'h10, 5'h16, 5'h18};
		check_val({shift, caps, kbw, spw, spr, scroll}, {5'h00, 5'h10}, "reset");
		for (int b = 1; b < 8; b++) begin
			if (b != 4 && b != 5) begin
				host_port_model_i.set_latch(3'(b), 1'b1);
			end
		end
		check_val({shift, caps, kbw, spw, spr}, 5'h1f, "indicators");
		for (int i = 0; i < 4; i++) begin
			host_port_model_i.set_latch(3'h5, codes[i][1]);
			host_port_model_i.set_latch(3'h4, codes[i][0]);
			check_val(scroll, kb[i], "scroll");
		end
		host_port_model_i.set_latch(3'h2, 1'b0);
		check_val({shift, caps, kbw, spw, spr}, 5'h1d, "hold");
	endtask

	// Every register select code, then remembered select and second bytes.
	task automatic test_commands();
		for (int r = 0; r < 8; r++) begin
			host_port_model_i.send_byte({1'b1, 3'(r), 4'(r) ^ 4'h9});
		end
		rd_check(8'h10, 32'h0000_0098, "tone3");
		rd_check(8'h0c, 32'h0000_00ba, "tone2");
		rd_check(8'h08, 32'h0000_00dc, "tone1");
		rd_check(8'h14, 32'h0000_007e, "noise");
		host_port_model_i.send_byte(8'h15);
		rd_check(8'h10, 32'h0000_0098, "ignored second byte");
		host_port_model_i.send_byte(8'h85);
		host_port_model_i.send_byte(8'h61);
		rd_check(8'h10, 32'h0000_2158, "second byte");
		host_port_model_i.send_byte(8'h3f);
		rd_check(8'h10, 32'h0000_3f58, "repeat second");
		for (int n = 0; n < 4; n++) begin
			host_port_model_i.send_byte({5'h1c, 1'(n), 2'(n)});
			rd_check(8'h14, {25'h0, 1'(n), 2'(n), 4'he}, "noise rate");
			check_val(noise, sound_pkg::LFSR_SEED[0], "noise restart");
		end
	endtask

	// Tone 1 period and mixed level in both phases; tone 1 has a short divisor
	// before, so the new one is reloaded within a few thousand cycles.
	task automatic test_tone();
		int t;
		logic prev;
		host_port_model_i.send_byte(8'hc2);
		host_port_model_i.send_byte(8'h00);
		host_port_model_i.send_byte(8'hd0);
		host_port_model_i.send_byte(8'h9f);
		host_port_model_i.send_byte(8'hbf);
		host_port_model_i.send_byte(8'hff);
		t = 0;
		for (int k = 0; k < 3; k++) begin
			prev = tone[0];
			while (tone[0] === prev && t < 4000) begin
				@(posedge clock_i);
				t++;
			end
			if (k > 0) begin
				check_val(t, 2 * sound_pkg::TICK_CYCLES, "half period");
			end
			repeat (10) @(posedge clock_i);
			check_val(mix, tone[0] ? 6'h0f : 6'h00, "mix");
			t = 10;
		end
	endtask

	// Control reset value, mute, and unmapped address.
	task automatic test_apb();
		logic [31:0] rd;
		logic err;
		rd_check(8'h00, 32'h0000_0001, "ctrl reset");
		apb(1'b0, 8'h1c, 32'h0000_0000, rd, err);
		check_val({err, rd}, {1'b1, 32'h0000_0000}, "unmapped");
		apb(1'b1, 8'h00, 32'hffff_fffe, rd, err);
		repeat (500) @(posedge clock_i);
		check_val(mix, 6'h00, "muted");
		rd_check(8'h00, 32'h0000_0000, "ctrl cleared");
		apb(1'b1, 8'h08, 32'hffff_ffff, rd, err);
		rd_check(8'h08, 32'h0000_0020, "tone1 write ignored");
		apb(1'b1, 8'h00, 32'h0000_0001, rd, err);
		rd_check(8'h00, 32'h0000_0001, "ctrl set");
		check_val(pready, 1'b1, "ready");
	endtask

	// Main sequence.
	initial begin
		reset_n_i <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(posedge clock_i);
		test_latch();
		test_commands();
		test_tone();
		test_apb();
		give_verdict();
	end
endmodule
`default_nettype wire
